// *** verilog/lcdw_pkg.sv ***
package lcdw_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned COLS = 40;
  localparam int unsigned ROWS = 4;
  localparam int unsigned PTR_W = 6;
  localparam int unsigned SUB_W = 3;
  localparam logic [PTR_W-1:0] LAST_COL = 6'h27;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RST = 6'h00;
  localparam logic [SUB_W-1:0] SUB_RST = 3'h0;
  localparam logic [SUB_W-1:0] SYNC_RST = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_STATIC = 2'h0,
    MODE_MUX2 = 2'h1,
    MODE_MUX3 = 2'h2,
    MODE_MUX4 = 2'h3
  } lcdw_mode_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } lcdw_st_e;

  typedef logic [COLS-1:0][ROWS-1:0] lcdw_ram_t;

  // Command strobes from the bus byte decoder, one pulse at a time
  typedef struct packed {
    logic ptr_load;
    logic [PTR_W-1:0] ptr_val;
    logic dev_sel;
    logic [SUB_W-1:0] dev_val;
    logic byte_vld;
    logic [7:0] byte_val;
  } lcdw_cmd_s;

  typedef struct packed {
    lcdw_st_e st;
    logic [PTR_W-1:0] ptr;
    logic [SUB_W-1:0] sub;
    logic [7:0] sh;
    logic [3:0] left;
    logic hit;
    logic ack;
    lcdw_ram_t ram;
  } lcdw_state_s;

endpackage : lcdw_pkg

// *** verilog/lcdw_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module lcdw_sync
  import lcdw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [SUB_W-1:0] pin_in,
  output logic [SUB_W-1:0] pin_sync
);

  typedef struct packed {
    logic [SUB_W-1:0] meta;
    logic [SUB_W-1:0] sync;
  } lcdw_sync_s;

  lcdw_sync_s s_r;
  lcdw_sync_s s_nxt;

  always_comb begin
    s_nxt.meta = pin_in;
    s_nxt.sync = s_r.meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{meta: SYNC_RST, sync: SYNC_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_sync = s_r.sync;

endmodule : lcdw_sync

`default_nettype wire

// *** verilog/lcdw_top.sv ***
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - A pointer-load command sets the data pointer that the next writes use.
// - Each data byte is written starting at the column the pointer holds.
// - Per byte the pointer moves on by 8, 4, 3 or 2 for static, 1:2, 1:3, 1:4.
// - After an aborted transfer the pointer value is not guaranteed.
// - Data is stored only while the subaddress counter equals the pins.
// - A device-select command loads the subaddress counter.
// - On a mismatch the store is dropped but the pointer still advances.
// - Each pointer overflow increments the subaddress counter by one.
// - A byte stream passes to the next device past the last column.
// - Bits go MSB first as 1, 2 or 4 bit words into rows 0 upward.
// - In 1:3 mode three words of 3, 3 and 2 bits fill rows 0 to 2.
// - Past the last column of device 7 the subaddress counter wraps to 0; a byte is acked if any of its words landed.
// - A stored one turns its display element on, a zero turns it off.
module lcdw_top
  import lcdw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire lcdw_cmd_s cmd,
  input wire lcdw_mode_e mode,
  input wire logic hw_subaddr_bit_zero,
  input wire logic hw_subaddr_bit_one,
  input wire logic hw_subaddr_bit_two,
  output logic busy,
  output logic byte_ack,
  output logic [PTR_W-1:0] data_ptr,
  output logic [SUB_W-1:0] subaddr_cnt,
  output lcdw_ram_t disp_ram
);

  // ----------------------------------------------------------------
  // Bits per RAM word for each drive mode
  // ----------------------------------------------------------------
  function automatic logic [2:0] word_bits(input lcdw_mode_e m);
    unique case (m)
      MODE_STATIC: word_bits = 3'h1;
      MODE_MUX2: word_bits = 3'h2;
      MODE_MUX3: word_bits = 3'h3;
      MODE_MUX4: word_bits = 3'h4;
    endcase
  endfunction : word_bits

  // ----------------------------------------------------------------
  // Hardware subaddress pins
  // ----------------------------------------------------------------
  logic [SUB_W-1:0] hw_sub;

  lcdw_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({hw_subaddr_bit_two, hw_subaddr_bit_one, hw_subaddr_bit_zero}),
    .pin_sync(hw_sub)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lcdw_state_s s_r;
  lcdw_state_s s_nxt;
  logic [2:0] take;
  logic match;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    take = word_bits(mode);
    if ({1'b0, take} > s_r.left) begin
      take = s_r.left[2:0];
    end
    match = (s_r.sub == hw_sub);
    unique case (s_r.st)
      ST_IDLE: begin
        if (cmd.ptr_load) begin
          // Out-of-range loads fall back to the first column
          if (cmd.ptr_val > LAST_COL) begin
            s_nxt.ptr = PTR_RST;
          end else begin
            s_nxt.ptr = cmd.ptr_val;
          end
        end
        if (cmd.dev_sel) begin
          s_nxt.sub = cmd.dev_val;
        end
        if (cmd.byte_vld) begin
          s_nxt.sh = cmd.byte_val;
          s_nxt.left = BYTE_BITS;
          s_nxt.hit = 1'b0;
          s_nxt.st = ST_RUN;
        end
      end
      ST_RUN: begin
        // One RAM word per cycle; rows above the word width keep their
        // old bits, which leaves row 2 alone in the short 1:3 word
        for (int r = 0; r < ROWS; r++) begin
          if (match && (r < int'(take))) begin
            s_nxt.ram[s_r.ptr][r] = s_r.sh[7-r];
          end
        end
        s_nxt.sh = s_r.sh << take;
        s_nxt.left = s_r.left - {1'b0, take};
        s_nxt.hit = s_r.hit | match;
        // Advance even on a mismatch so cascaded parts stay in step
        if (s_r.ptr == LAST_COL) begin
          s_nxt.ptr = PTR_RST;
          s_nxt.sub = s_r.sub + 3'h1;
        end else begin
          s_nxt.ptr = s_r.ptr + 6'h01;
        end
        if (s_nxt.left == 4'h0) begin
          s_nxt.st = ST_IDLE;
          // No word landed here: another device or nobody acknowledges
          s_nxt.ack = s_r.hit | match;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: ST_IDLE, ptr: PTR_RST, sub: SUB_RST, sh: 8'h00,
               left: 4'h0, hit: 1'b0, ack: 1'b0, ram: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busy = (s_r.st == ST_RUN);
  assign byte_ack = s_r.ack;
  assign data_ptr = s_r.ptr;
  assign subaddr_cnt = s_r.sub;
  assign disp_ram = s_r.ram;

endmodule : lcdw_top

`default_nettype wire

// *** sim/lcdw_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module lcdw_checker
  import lcdw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire lcdw_cmd_s cmd,
  input wire lcdw_mode_e mode,
  input wire logic busy,
  input wire logic byte_ack,
  input wire logic [PTR_W-1:0] data_ptr,
  input wire logic [SUB_W-1:0] subaddr_cnt
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic ld, go;
  // A byte strobe with a pointer load in one cycle is left out: their order is a design choice
  assign ld = !busy && !cmd.byte_vld;
  assign go = !busy && cmd.byte_vld && !cmd.ptr_load;
  chk_ptr_load:
    assert property (ld && cmd.ptr_load && cmd.ptr_val < 6'h28
      |=> data_ptr == $past(cmd.ptr_val)) else $error("ptr load");
  chk_sub_load:
    assert property (ld && cmd.dev_sel
      |=> subaddr_cnt == $past(cmd.dev_val)) else $error("sub load");
  chk_busy_start:
    assert property (go |=> busy) else $error("no busy");
  chk_quad_step:
    assert property (go && mode == MODE_MUX4 && data_ptr < 6'h26
      |=> ##2 data_ptr == $past(data_ptr, 3) + 6'h2) else $error("step 2");
  chk_static_step:
    assert property (go && mode == MODE_STATIC && data_ptr < 6'h20
      |=> ##8 data_ptr == $past(data_ptr, 9) + 6'h8) else $error("step 8");
  chk_quad_busy:
    assert property ($rose(busy) && mode == MODE_MUX4
      |-> busy [*2] ##1 !busy) else $error("busy len");
  chk_wrap_inc:
    assert property ($changed(subaddr_cnt) && !$past(cmd.dev_sel)
      |-> subaddr_cnt == $past(subaddr_cnt) + 3'h1 && data_ptr == PTR_RST)
      else $error("wrap");
  chk_ack_end:
    assert property (byte_ack |-> !busy && $past(busy)) else $error("ack");
  cover property (byte_ack);
  cover property (go && mode == MODE_MUX3);
  cover property (busy && $changed(subaddr_cnt));
endmodule : lcdw_checker
bind lcdw_top lcdw_checker u_chk (.clk(clk), .rst(rst), .cmd(cmd),
  .mode(mode), .busy(busy), .byte_ack(byte_ack), .data_ptr(data_ptr),
  .subaddr_cnt(subaddr_cnt));
`default_nettype wire

// *** sim/lcdw_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module lcdw_host
  import lcdw_pkg::*;
(
  input wire logic clk,
  input wire logic busy,
  output var lcdw_cmd_s cmd
);
  initial cmd = '0;
  // Strobes drop and data fields flip so stale data is never mistaken for a command
  task automatic send(input lcdw_cmd_s c);
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= {1'b0, ~c.ptr_val, 1'b0, ~c.dev_val, 1'b0, ~c.byte_val};
    @(negedge clk);
    repeat (9) if (busy) @(negedge clk);
  endtask : send
endmodule : lcdw_host
`default_nettype wire

// *** sim/lcdw_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module lcdw_top_tb
  import lcdw_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lcdw_mode_e mode = MODE_STATIC;
  logic [2:0] pins = 3'h0;
  lcdw_cmd_s cmd;
  logic busy, ack;
  logic [5:0] ptr;
  logic [2:0] sub;
  lcdw_ram_t ram;
  int errors = 0;
  int checks_done = 0;
  always #20 clk = ~clk;
  lcdw_host host (.clk(clk), .busy(busy), .cmd(cmd));
  lcdw_top dut (.clk(clk), .rst(rst), .cmd(cmd), .mode(mode),
    .hw_subaddr_bit_zero(pins[0]), .hw_subaddr_bit_one(pins[1]),
    .hw_subaddr_bit_two(pins[2]), .busy(busy), .byte_ack(ack),
    .data_ptr(ptr), .subaddr_cnt(sub), .disp_ram(ram));
  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic wr(input lcdw_mode_e m, input logic [5:0] a,
    input logic [2:0] d, input logic [7:0] b);
    @(posedge clk) mode <= m;
    host.send({1'b1, a, 13'h0});
    host.send({7'h0, 1'b1, d, 9'h0});
    host.send({11'h0, 1'b1, b});
  endtask : wr
  task automatic t_mux4();
    wr(MODE_MUX4, 6'h05, 3'h0, 8'ha5);
    chk("c5", {4'h0, ram[5]}, 8'h05);
    chk("c6", {4'h0, ram[6]}, 8'h0a);
    chk("ptr", {2'h0, ptr}, 8'h07);
    chk("ack", {7'h0, ack}, 8'h01);
  endtask : t_mux4
  task automatic t_mux3();
    wr(MODE_MUX3, 6'h0a, 3'h0, 8'hff);
    chk("c12", {4'h0, ram[12]}, 8'h03);
    chk("ptr", {2'h0, ptr}, 8'h0d);
  endtask : t_mux3
  task automatic t_wrap();
    wr(MODE_STATIC, 6'h24, 3'h0, 8'ha5);
    chk("c36", {4'h0, ram[36]}, 8'h01);
    chk("c3", {4'h0, ram[3]}, 8'h00);
    chk("sub", {5'h0, sub}, 8'h01);
  endtask : t_wrap
  task automatic t_skip();
    wr(MODE_MUX2, 6'h14, 3'h2, 8'hff);
    chk("sub", {5'h0, sub}, 8'h02);
    chk("c20", {4'h0, ram[20]}, 8'h00);
    chk("ptr", {2'h0, ptr}, 8'h18);
    chk("ack", {7'h0, ack}, 8'h00);
  endtask : t_skip
  task automatic t_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("rst_ptr", {2'h0, ptr}, 8'h00);
    chk("rst_sub", {5'h0, sub}, 8'h00);
    chk("rst_c5", {4'h0, ram[5]}, 8'h00);
    chk("rst_busy", {7'h0, busy}, 8'h00);
    repeat (3) @(posedge clk);
    wr(MODE_STATIC, 6'h08, 3'h0, 8'h81);
    chk("c8", {4'h0, ram[8]}, 8'h01);
    chk("c15", {4'h0, ram[15]}, 8'h01);
    chk("ptr", {2'h0, ptr}, 8'h10);
    chk("ack", {7'h0, ack}, 8'h01);
  endtask : t_reset
  task automatic t_cascade();
    @(posedge clk) pins <= 3'h1;
    wr(MODE_STATIC, 6'h24, 3'h0, 8'h5a);
    chk("c39", {4'h0, ram[39]}, 8'h00);
    chk("c0", {4'h0, ram[0]}, 8'h01);
    chk("c2", {4'h0, ram[2]}, 8'h01);
    chk("ack", {7'h0, ack}, 8'h01);
    chk("sub", {5'h0, sub}, 8'h01);
    host.send({1'b1, 6'h2a, 13'h0});
    chk("ptr", {2'h0, ptr}, 8'h00);
  endtask : t_cascade
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_mux4();
    t_mux3();
    t_wrap();
    t_skip();
    t_reset();
    t_cascade();
    results();
  end
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    results();
  end
endmodule : lcdw_top_tb
`default_nettype wire
